// ---- bench/pic_core_model.sv ----
// Behavioural core beside the interrupt controller.
// Assumes pic_pkg; the bench supplies the instruction events.
`timescale 1ns/10ps
`default_nettype none
module pic_core_model
   import pic_pkg::*;
#(
   parameter int DONE_DLY = 2
)
(
   // Clock and reset
   input  wire logic     clock,
   input  wire logic     reset_n,
   // Controller and bench side
   input  wire logic     handler_fetch,
   input  wire pic_cpu_s cmd,
   output var  pic_cpu_s cpu_evt
);
   logic [3:0] cnt_r;

   // Time the first handler instruction from the fetch
   always_ff @(posedge clock) begin
      if (!reset_n)
         cnt_r <= 4'h0;
      else if (handler_fetch)
         cnt_r <= 4'(DONE_DLY);
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end

   // Bench events pass through; completion stands one cycle
   always_comb begin
      cpu_evt = cmd;
      cpu_evt.instr_done = (cnt_r == 4'h1);
   end
endmodule // pic_core_model
`default_nettype wire

// ---- bench/pic_top_properties.sv ----
// Port-level assertions on the interrupt controller.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module pic_top_properties
   import pic_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // Watched ports
   input wire pic_cpu_s    cpu_evt,
   input wire logic        vec_read,
   input wire logic [7:0]  vec_value,
   input wire logic        handler_fetch,
   input wire logic [23:0] fetch_addr,
   input wire logic        seq_busy,
   input wire pic_stack_s  stack,
   input wire pic_micro_s  micro_transfer,
   input wire pic_lvl_t    fwd_level,
   input wire pic_lvl_t    interrupt_mask_level,
   input wire logic [7:0]  nesting_depth_counter,
   input wire logic [23:0] system_stack_pointer
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Mask after acceptance; level 7 saturates
   wire pic_lvl_t lvl_up = (fwd_level == 3'h7) ? 3'h7 : fwd_level + 3'h1;
   // Instruction mask writes count only outside the sequence
   wire logic idle_cmd = !seq_busy && !cpu_evt.return_from_handler;

   a_reset_mask: assert property ($rose(reset_n) |-> interrupt_mask_level == 3'h7)
      else $error("mask not all ones after reset");
   a_accept_level: assert property (vec_read |-> fwd_level >= $past(interrupt_mask_level))
      else $error("accepted below mask");
   a_push_frame: assert property (vec_read |-> ##2 stack.push)
      else $error("no push after vector read");
   a_push_addr: assert property (stack.push |-> stack.addr == system_stack_pointer)
      else $error("push address differs from stack pointer");
   a_mask_update: assert property (vec_read |-> ##4
      interrupt_mask_level == $past(lvl_up, 4))
      else $error("mask after acceptance wrong");
   a_nest_inc: assert property (vec_read |-> ##4
      nesting_depth_counter == $past(nesting_depth_counter, 4) + 8'h01)
      else $error("nesting not incremented");
   a_fetch_addr: assert property (handler_fetch |-> fetch_addr == {16'hFFFF, vec_value})
      else $error("handler address wrong");
   a_seq_length: assert property (vec_read |-> ##17 handler_fetch)
      else $error("sequence length wrong");
   a_ret_pop: assert property (cpu_evt.return_from_handler && !seq_busy |=>
      nesting_depth_counter == $past(nesting_depth_counter) - 8'h01)
      else $error("return did not decrement nesting");
   a_pop_addr: assert property (stack.pop |->
      system_stack_pointer == stack.addr + 24'h000006)
      else $error("pop did not release the frame");
   a_no_sample: assert property (seq_busy && $past(seq_busy) |-> !vec_read)
      else $error("acceptance inside sequence");
   a_set_mask: assert property (cpu_evt.set_mask_instruction &&
      !cpu_evt.disable_instruction && idle_cmd |=>
      interrupt_mask_level == $past(cpu_evt.operand))
      else $error("set-mask not applied");
   a_disable_mask: assert property (cpu_evt.disable_instruction && idle_cmd |=>
      interrupt_mask_level == 3'h7)
      else $error("disable did not mask");

   c_nmi: cover property (vec_read && vec_value == 8'h20);
   c_micro: cover property (micro_transfer.go);
   c_return: cover property (cpu_evt.return_from_handler && !seq_busy);
endmodule // pic_top_properties

bind pic_top pic_top_properties chk_u (.clock, .reset_n, .cpu_evt, .vec_read, .vec_value,
   .handler_fetch, .fetch_addr, .seq_busy, .stack, .micro_transfer, .fwd_level,
   .interrupt_mask_level, .nesting_depth_counter, .system_stack_pointer);
`default_nettype wire

// ---- bench/prioritised_interrupt_controller_tb.sv ----
// Self-checking bench for the interrupt controller.
// Assumes pic_pkg, pic_top, the core model and the checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module prioritised_interrupt_controller_tb
   import pic_pkg::*;
;
   logic            clock, reset_n, ill, nmi, wd, swq, fwd_valid;
   logic            vec_read, handler_fetch, seq_busy;
   logic [7:0]      trap, vec_value, nest;
   logic [46:0]     ev, clr, route;
   pic_lvl_t [46:0] lvl;
   logic [5:0]      swc;
   pic_cpu_s        cmd, cpu_evt;
   pic_lvl_t        fwd_level, mask;
   logic [23:0]     fetch_addr, sp;
   pic_stack_s      stack;
   pic_micro_s      micro;
   int              failures = 0;
   int              checks = 0;

   pic_core_model #(.DONE_DLY(2)) core_u (.clock, .reset_n, .handler_fetch, .cmd, .cpu_evt);

   pic_top dut_u (.clock, .reset_n, .software_trap(trap), .illegal_opcode_event(ill),
      .nmi_pin_event(nmi), .watchdog_event(wd), .mask_src_event(ev), .mask_src_clear(clr),
      .level_cfg(lvl), .micro_route(route), .cpu_evt, .cur_pc(24'h123456),
      .status_word(16'hABCD), .sw_micro_req(swq), .sw_micro_code(swc), .fwd_valid,
      .fwd_level, .vec_read, .vec_value, .handler_fetch, .fetch_addr, .seq_busy, .stack,
      .micro_transfer(micro), .interrupt_mask_level(mask), .nesting_depth_counter(nest),
      .system_stack_pointer(sp));

   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic tk(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input string nm, input logic [47:0] got, exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One-cycle instruction event; the operand doubles as popped mask
   task automatic op(input logic s, d, r, input pic_lvl_t v);
      cmd = '{s, d, r, 1'b0, v, v};
      tk();
      cmd = '0;
      tk();
   endtask

   // Follow one acceptance through to its first instruction
   task automatic acc(input logic [7:0] v);
      int i;
      for (i = 0; i < 30 && vec_read !== 1'b1; i++) tk();
      chk("vec_read", vec_read, 1'b1);
      chk("vec_value", vec_value, v);
      chk("fwd_valid", fwd_valid, 1'b1);
      tk(2); // Push lands two cycles after the vector read
      chk("push", {stack.push, stack.data}, {1'b1, 24'h123456, 16'hABCD});
      for (i = 0; i < 30 && handler_fetch !== 1'b1; i++) tk();
      chk("fetch_addr", fetch_addr, {16'hFFFF, v});
      for (i = 0; i < 10 && seq_busy !== 1'b0; i++) tk();
      chk("seq_busy", seq_busy, 1'b0);
   endtask

   // Watch a stretch in which nothing may be accepted
   task automatic none(input string nm);
      int i, hit;
      hit = 0;
      for (i = 0; i < 25; i++) begin
         tk();
         if (vec_read !== 1'b0) hit = 1;
      end
      chk(nm, hit, 0);
   endtask

   task automatic wgo(input logic [5:0] c);
      int i;
      for (i = 0; i < 30 && micro.go !== 1'b1; i++) tk();
      chk("micro", {micro.go, micro.code}, {1'b1, c});
   endtask

   task automatic t_fixed();
      int n;
      chk("mask_reset", mask, 3'h7);
      chk("fetch_reset", fetch_addr, 24'hFFFF00);
      for (n = 0; n < 10; n++) begin
         {trap, nmi, wd} = {8'(n < 8) << n, n == 8, n == 9};
         tk();
         {trap, nmi, wd} = '0;
         acc(8'(n * 4));
         chk("mask", mask, 3'h7);
         chk("nest", nest, 8'h01);
         op(1'b0, 1'b0, 1'b1, 3'h7);
         chk("pop", {nest, sp}, 32'h0);
      end
   endtask

   task automatic t_level();
      op(1'b1, 1'b0, 1'b0, 3'h3);
      chk("mask_set", mask, 3'h3);
      lvl[2:0] = {3'h3, 3'h3, 3'h2};
      ev[2:0] = 3'h7;
      tk();
      ev = '0;
      acc(8'h2C);
      chk("mask", mask, 3'h4);
      op(1'b0, 1'b0, 1'b1, 3'h3);
      acc(8'h30);
      op(1'b0, 1'b0, 1'b1, 3'h3);
      none("below_mask");
      chk("fwd_pend", {fwd_valid, fwd_level}, {1'b1, 3'h2});
      clr[0] = 1'b1;
      tk();
      clr = '0;
      op(1'b1, 1'b0, 1'b0, 3'h2);
      none("cleared");
   endtask

   task automatic t_disable();
      op(1'b0, 1'b1, 1'b0, 3'h0);
      chk("mask_dis", mask, 3'h7);
      lvl[3] = 3'h6;
      ev[3] = 1'b1;
      tk();
      ev = '0;
      none("disabled");
      op(1'b1, 1'b0, 1'b0, 3'h0);
      acc(8'h34);
      op(1'b0, 1'b0, 1'b1, 3'h0);
      lvl[5:4] = {3'h7, 3'h0};
      ev[5:4] = 2'h3;
      tk();
      ev = '0;
      none("level_off");
   endtask

   // Illegal opcode raised in the cycle the level-2 request is accepted
   task automatic t_nest();
      lvl[6] = 3'h2;
      ev[6] = 1'b1;
      tk();
      {ev[6], ill} = 2'b01;
      tk();
      ill = 1'b0;
      acc(8'h40);
      acc(8'h08);
      chk("nest2", nest, 8'h02);
      op(1'b0, 1'b0, 1'b1, 3'h3);
      op(1'b0, 1'b0, 1'b1, 3'h0);
      chk("nest0", nest, 8'h00);
   endtask

   task automatic t_micro();
      {swc, swq} = {6'h0A, 1'b1};
      tk();
      swq = 1'b0;
      wgo(6'h0A);
      op(1'b1, 1'b0, 1'b0, 3'h6);
      {route[7], lvl[7], ev[7]} = {1'b1, 3'h1, 1'b1};
      tk();
      ev = '0;
      wgo(6'h11);
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial begin
      {reset_n, ill, nmi, wd, swq, trap, ev, clr, route, swc, lvl, cmd} = '0;
      tk(8);
      reset_n = 1'b1;
      t_fixed();
      t_level();
      t_disable();
      t_nest();
      t_micro();
      final_report();
   end

   // Cut a hang short well past the expected run
   initial begin
      #200000;
      failures++;
      final_report();
   end
endmodule // prioritised_interrupt_controller_tb
`default_nettype wire

// ---- design/pic_map.svh ----
// Constants of the prioritised interrupt controller: counts, levels, timing.
// Assumes nothing; included by the package and the top module.
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// Source counts and index layout (index = vector / 4)
`define PIC_N_SRC        57
`define PIC_N_NMI        10
`define PIC_N_MSK        47
`define PIC_IDX_UNDEF    2
`define PIC_IDX_NMI      8
`define PIC_IDX_WD       9
`define PIC_MICRO_FIRST  10
`define PIC_MICRO_LAST   51

// Levels
`define PIC_LVL_NMI      3'h7
`define PIC_LVL_MICRO    3'h6
`define PIC_LVL_OFF      3'h0
`define PIC_MASK_RESET   3'h7

// Vector area and stack
`define PIC_VEC_BASE     24'hFFFF00
`define PIC_SP_RESET     24'h000000
`define PIC_STACK_FRAME  24'h000006

// Acceptance sequence, one state per clock (25 MHz, 40 ns)
`define PIC_SEQ_STATES   5'h12
`define PIC_SEQ_PUSH     5'h02
`define PIC_SEQ_MASK     5'h04
`define PIC_SEQ_LAST     5'h11

`endif

// ---- design/pic_pkg.sv ----
// Types shared by the prioritised interrupt controller.
// Assumes pic_map.svh is on the include path.
`default_nettype none
`include "pic_map.svh"

package pic_pkg;

   typedef logic [2:0] pic_lvl_t;

   // Sequence states, Gray along idle -> sequence -> first instruction
   typedef enum logic [1:0] {
      PIC_IDLE  = 2'h0,
      PIC_SEQ   = 2'h1,
      PIC_FIRST = 2'h3
   } pic_state_e;

   // Instruction events reported by the core, one-cycle pulses
   typedef struct packed {
      logic     set_mask_instruction;
      logic     disable_instruction;
      logic     return_from_handler;
      logic     instr_done;
      pic_lvl_t operand;
      pic_lvl_t pop_mask;
   } pic_cpu_s;

   // Stack traffic towards the core's memory port
   typedef struct packed {
      logic        push;
      logic        pop;
      logic [23:0] addr;
      logic [39:0] data;
   } pic_stack_s;

   // Micro transfer trigger
   typedef struct packed {
      logic       go;
      logic [5:0] code;
   } pic_micro_s;

endpackage

`default_nettype wire

// ---- design/pic_top.sv ----
// Prioritised interrupt controller with the core's acceptance sequence.
// Assumes one 25 MHz clock, synchronous inputs and one-cycle event pulses.
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.svh"

// Functional notes
// RULE_01: Non-maskable sources sit at level 7; maskable ones carry a programmed level.
// RULE_02: Only the highest pending level is forwarded to the core.
// RULE_03: Acceptance when forwarded level is equal to or above the mask level.
// RULE_04: Set-mask instruction loads its operand; effective from the next cycle.
// RULE_05: Disable instruction loads mask level 7.
// RULE_06: Equal levels resolve to the smaller vector; vector read clears it.
// RULE_07: After the vector read, program counter and status word are pushed.
// RULE_08: Mask becomes accepted level plus one, or stays 7 for level 7.
// RULE_09: Each acceptance increments the nesting depth counter.
// RULE_10: Handler address fetched from vector-area base plus vector value.
// RULE_11: Acceptance sequence lasts 18 states.
// RULE_12: Return pops counter and status word and decrements nesting depth.
// RULE_13: Non-maskable sources cannot be disabled; level 0 or 7 never requests.
// RULE_14: New requests are not sampled until the handler's first instruction ends.
// RULE_15: Reset sets the mask level to all ones.
// RULE_16: Vector area is 256 bytes at the top of the address space.
// RULE_17: 57 sources: 9 traps, 12 pins with non-maskable pin, 36 internal.
// RULE_18: Fixed vectors, spaced by four; index is the vector divided by four.
// RULE_19: Illegal opcode shares vector 0008H with software trap 2.
// RULE_20: Pin requests may trigger micro transfers; code is vector divided by four.
// RULE_21: Micro mode moves data per request; software may issue requests too.
// RULE_22: Micro-routed requests are served at level 6 whatever their level.
// RULE_23: Pending requests stay latched until vector read or software clear.
module pic_top
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      reset_n,
   // Non-maskable sources, one-cycle pulses
   input  wire logic [7:0]                software_trap,
   input  wire logic                      illegal_opcode_event,
   input  wire logic                      nmi_pin_event,
   input  wire logic                      watchdog_event,
   // Maskable sources, ext_pin_request_0 is bit 0
   input  wire logic [`PIC_N_MSK-1:0]     mask_src_event,
   input  wire logic [`PIC_N_MSK-1:0]     mask_src_clear,
   input  wire pic_lvl_t [`PIC_N_MSK-1:0] level_cfg,
   input  wire logic [`PIC_N_MSK-1:0]     micro_route,
   // Core side
   input  wire pic_cpu_s                  cpu_evt,
   input  wire logic [23:0]               cur_pc,
   input  wire logic [15:0]               status_word,
   input  wire logic                      sw_micro_req,
   input  wire logic [5:0]                sw_micro_code,
   // Forwarded request
   output var  logic                      fwd_valid,
   output var  pic_lvl_t                  fwd_level,
   // Acceptance sequence
   output var  logic                      vec_read,
   output var  logic [7:0]                vec_value,
   output var  logic                      handler_fetch,
   output var  logic [23:0]               fetch_addr,
   output var  logic                      seq_busy,
   output var  pic_stack_s                stack,
   output var  pic_micro_s                micro_transfer,
   // Core state
   output var  pic_lvl_t                  interrupt_mask_level,
   output var  logic [7:0]                nesting_depth_counter,
   output var  logic [23:0]               system_stack_pointer
);

   // Effective level of one source; 0 means no request
   function automatic pic_lvl_t eff_level(input int idx, input pic_lvl_t cfg,
                                          input logic route);
      pic_lvl_t lvl;
      lvl = `PIC_LVL_OFF;
      if (idx < `PIC_N_NMI) begin
         lvl = `PIC_LVL_NMI; // RULE_01
      end else if (route && idx >= `PIC_MICRO_FIRST && idx <= `PIC_MICRO_LAST) begin
         lvl = `PIC_LVL_MICRO; // RULE_22
      end else if (cfg != `PIC_LVL_NMI) begin
         lvl = cfg; // RULE_13
      end
      return lvl;
   endfunction

   // Mask value written on acceptance
   function automatic pic_lvl_t next_mask(input pic_lvl_t lvl);
      return (lvl == `PIC_LVL_NMI) ? `PIC_LVL_NMI : pic_lvl_t'(lvl + 3'h1); // RULE_08
   endfunction

   // Vector value of a source index; vectors are spaced by four
   function automatic logic [7:0] vec_of(input logic [5:0] idx);
      return {idx, 2'b00}; // RULE_18
   endfunction

   logic [`PIC_N_SRC-1:0] pend_r;
   logic [`PIC_N_SRC-1:0] pend_set;
   logic [`PIC_N_SRC-1:0] pend_clr;
   logic [`PIC_N_SRC-1:0] route_all;
   pic_lvl_t              win_lvl;
   logic [5:0]            win_idx;
   logic                  win_valid;
   logic                  accept;
   logic                  win_micro;
   pic_state_e            state_r;
   pic_state_e            state_nxt;
   logic [4:0]            seq_cnt_r;
   logic [5:0]            acc_idx_r;
   pic_lvl_t              acc_lvl_r;
   logic                  at_push;
   logic                  at_mask;
   logic                  at_last;

   // Raise events into vector-indexed request bits
   // Trap 2 and the illegal opcode share one request bit
   always_comb begin
      pend_set = '0;
      pend_set[7:0] = software_trap;
      pend_set[`PIC_IDX_UNDEF] = software_trap[2] | illegal_opcode_event; // RULE_19
      pend_set[`PIC_IDX_NMI] = nmi_pin_event;
      pend_set[`PIC_IDX_WD] = watchdog_event;
      pend_set[`PIC_N_SRC-1:`PIC_N_NMI] = mask_src_event; // RULE_17
   end

   // Routing flags widened to the full index space
   always_comb begin
      route_all = '0;
      route_all[`PIC_N_SRC-1:`PIC_N_NMI] = micro_route;
   end

   // Highest level wins; scanning downward lets the smaller vector take ties
   // One 57-way scan per cycle; short enough at 25 MHz, so no pipelining
   always_comb begin
      pic_lvl_t l;
      l = `PIC_LVL_OFF;
      win_lvl = `PIC_LVL_OFF;
      win_idx = 6'h00;
      for (int i = `PIC_N_SRC - 1; i >= 0; i--) begin
         if (i < `PIC_N_NMI) begin
            l = eff_level(i, `PIC_LVL_OFF, 1'b0);
         end else begin
            l = eff_level(i, level_cfg[i-`PIC_N_NMI], route_all[i]);
         end
         if (pend_r[i] && l != `PIC_LVL_OFF && l >= win_lvl) begin // RULE_02
            win_lvl = l; // RULE_06
            win_idx = 6'(i);
         end
      end
   end

   assign win_valid = (win_lvl != `PIC_LVL_OFF);
   assign win_micro = route_all[win_idx] && win_idx >= 6'(`PIC_MICRO_FIRST)
                      && win_idx <= 6'(`PIC_MICRO_LAST);

   // Only sampled when idle, never inside the sequence or before first instruction
   assign accept = (state_r == PIC_IDLE) && win_valid
                   && (win_lvl >= interrupt_mask_level); // RULE_03 RULE_14

   // Sequence step decodes, shared by stack, mask, nesting and fetch logic
   assign at_push = (state_r == PIC_SEQ) && (seq_cnt_r == `PIC_SEQ_PUSH);
   assign at_mask = (state_r == PIC_SEQ) && (seq_cnt_r == `PIC_SEQ_MASK);
   assign at_last = (state_r == PIC_SEQ) && (seq_cnt_r == `PIC_SEQ_LAST);

   // Clear on vector read, or by software for maskable sources only
   always_comb begin
      pend_clr = '0;
      pend_clr[`PIC_N_SRC-1:`PIC_N_NMI] = mask_src_clear; // RULE_13
      if (accept) begin
         pend_clr[win_idx] = 1'b1; // RULE_06
      end
   end

   // Request latches; a new event beats a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~pend_clr) | pend_set; // RULE_23
      end
   end

   // Forwarded level towards the core
   // Registered, so the level trails the request bits by one cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         fwd_valid <= 1'b0;
         fwd_level <= `PIC_LVL_OFF;
      end else begin
         fwd_valid <= win_valid;
         fwd_level <= win_lvl; // RULE_02
      end
   end

   // Sequence state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PIC_IDLE: begin
            if (accept && !win_micro) begin
               state_nxt = PIC_SEQ;
            end
         end
         PIC_SEQ: begin
            if (seq_cnt_r == `PIC_SEQ_LAST) begin
               state_nxt = PIC_FIRST;
            end
         end
         PIC_FIRST: begin
            if (cpu_evt.instr_done) begin
               state_nxt = PIC_IDLE; // RULE_14
            end
         end
         default: begin
            state_nxt = PIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= PIC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // State counter: vector read is state 0, fetch is state 17
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         seq_cnt_r <= 5'h00;
      end else if (state_r == PIC_IDLE && state_nxt == PIC_SEQ) begin
         seq_cnt_r <= 5'h01;
      end else if (state_r == PIC_SEQ && seq_cnt_r < `PIC_SEQ_LAST) begin
         seq_cnt_r <= seq_cnt_r + 5'h01; // RULE_11
      end else begin
         seq_cnt_r <= 5'h00;
      end
   end

   // Accepted request captured at the vector read
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         acc_idx_r <= 6'h00;
         acc_lvl_r <= `PIC_LVL_OFF;
      end else if (accept) begin
         acc_idx_r <= win_idx;
         acc_lvl_r <= win_lvl;
      end
   end

   // Vector read pulse and value
   // Value holds after the pulse so the core may pick it up late
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         vec_read  <= 1'b0;
         vec_value <= 8'h00;
      end else begin
         vec_read <= accept && !win_micro;
         if (accept && !win_micro) begin
            vec_value <= vec_of(win_idx); // RULE_18
         end
      end
   end

   // Handler fetch at the last state of the sequence
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         handler_fetch <= 1'b0;
         fetch_addr    <= `PIC_VEC_BASE;
      end else begin
         handler_fetch <= at_last; // RULE_11
         if (at_last) begin
            fetch_addr <= `PIC_VEC_BASE + {16'h0000, vec_of(acc_idx_r)}; // RULE_10 RULE_16
         end
      end
   end

   // Busy from acceptance until the handler's first instruction ends
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         seq_busy <= 1'b0;
      end else begin
         seq_busy <= (state_nxt != PIC_IDLE);
      end
   end

   // Stack push during the sequence, pop on return
   // A return in the push step loses its pop; the core cannot retire one mid-sequence
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         stack                <= '0;
         system_stack_pointer <= `PIC_SP_RESET;
      end else begin
         stack.push <= 1'b0;
         stack.pop  <= 1'b0;
         if (at_push) begin
            stack.push           <= 1'b1; // RULE_07
            stack.addr           <= system_stack_pointer - `PIC_STACK_FRAME;
            stack.data           <= {cur_pc, status_word};
            system_stack_pointer <= system_stack_pointer - `PIC_STACK_FRAME;
         end else if (cpu_evt.return_from_handler) begin
            stack.pop            <= 1'b1; // RULE_12
            stack.addr           <= system_stack_pointer;
            system_stack_pointer <= system_stack_pointer + `PIC_STACK_FRAME;
         end
      end
   end

   // Mask level: acceptance, return, then instructions
   // The acceptance step outranks instructions; the core issues none mid-sequence
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         interrupt_mask_level <= `PIC_MASK_RESET; // RULE_15
      end else if (at_mask) begin
         interrupt_mask_level <= next_mask(acc_lvl_r); // RULE_08
      end else if (cpu_evt.return_from_handler) begin
         interrupt_mask_level <= cpu_evt.pop_mask; // RULE_12
      end else if (cpu_evt.disable_instruction) begin
         interrupt_mask_level <= `PIC_LVL_NMI; // RULE_05
      end else if (cpu_evt.set_mask_instruction) begin
         interrupt_mask_level <= cpu_evt.operand; // RULE_04
      end
   end

   // Nesting depth; wraps silently, software keeps it balanced
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         nesting_depth_counter <= 8'h00;
      end else if (at_mask) begin
         nesting_depth_counter <= nesting_depth_counter + 8'h01; // RULE_09
      end else if (cpu_evt.return_from_handler) begin
         nesting_depth_counter <= nesting_depth_counter - 8'h01; // RULE_12
      end
   end

   // Micro transfer trigger instead of a handler; hardware beats software
   // A software request beaten by hardware is dropped; software must reissue it
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         micro_transfer <= '0;
      end else if (accept && win_micro) begin
         micro_transfer.go   <= 1'b1; // RULE_20 RULE_21
         micro_transfer.code <= win_idx;
      end else if (sw_micro_req) begin
         micro_transfer.go   <= 1'b1; // RULE_21
         micro_transfer.code <= sw_micro_code;
      end else begin
         micro_transfer.go <= 1'b0;
      end
   end

endmodule // pic_top

`default_nettype wire
